// [shared/sphc_pkg.sv]
/*
 Constants and types for the speech payload header codec.
 Assumes inclusion before every design file of the block.
*/
package sphc_pkg;
   // Header byte layout
   localparam int TYPE_FLAG_BIT = 7;
   localparam int FOLLOW_BIT = 6;
   localparam int REQ_TYPE_MSB = 6;
   localparam int REQ_TYPE_LSB = 4;
   localparam int REQ_VAL_MSB = 3;
   localparam int REQ_VAL_LSB = 0;
   // Request type codes
   localparam logic [2:0] RT_NARROW = 3'h0;
   localparam logic [2:0] RT_LEGACY = 3'h1;
   localparam logic [2:0] RT_WIDE = 3'h2;
   localparam logic [2:0] RT_SUPERWIDE = 3'h3;
   localparam logic [2:0] RT_FULL = 3'h4;
   localparam logic [2:0] RT_CA_WIDE = 3'h5;
   localparam logic [2:0] RT_CA_SUPER = 3'h6;
   localparam logic [2:0] RT_NOREQ = 3'h7;
   // Valid value code limits per type (maximums, minimums, no-request code)
   localparam logic [3:0] NB_MAX = 4'h6;
   localparam logic [3:0] LEG_MAX = 4'h8;
   localparam logic [3:0] WB_MAX = 4'hb;
   localparam logic [3:0] SWB_MIN = 4'h3;
   localparam logic [3:0] FB_MIN = 4'h5;
   localparam logic [3:0] CA_MAX = 4'h7;
   localparam logic [3:0] NOREQ_CODE = 4'hf;
   // Reset values of the latched request
   localparam logic [2:0] REQ_TYPE_RST = 3'h7;
   localparam logic [3:0] REQ_VAL_RST = 4'hf;
   // Register offsets and reset values
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_ALLOW = 4'h4;
   localparam logic [3:0] OFS_TXREQ = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] ALLOW_RST = 8'hff;
   localparam logic [7:0] TXREQ_RST = 8'hff;

   // Decoded request class
   typedef enum logic [2:0] {
      SPHC_CL_NONE = 3'b000,
      SPHC_CL_RATE = 3'b001,
      SPHC_CL_LEGACY = 3'b010,
      SPHC_CL_CHANAWARE = 3'b011,
      SPHC_CL_INVALID = 3'b100
   } sphc_class_type;

   // Parser states
   typedef enum logic [1:0] {
      SPHC_P_FIRST = 2'b00,
      SPHC_P_TOC = 2'b01,
      SPHC_P_DATA = 2'b10
   } sphc_pstate_type;
endpackage

// [hw/sphc_req_decode.sv]
/*
 Combinational decoder of one rate-request byte.
 Assumes a byte with the type flag already known to be set.
*/
`timescale 1ns/1ps
module sphc_req_decode
   import sphc_pkg::*;
(
   input wire logic [7:0] req_byte,
   input wire logic [7:0] allow_mask,
   output sphc_pkg::sphc_class_type req_class,
   output logic chanaware_high,
   output logic [1:0] chanaware_offset_idx
);
   logic [2:0] rtype;
   logic [3:0] rval;
   assign rtype = req_byte[REQ_TYPE_MSB:REQ_TYPE_LSB];
   assign rval = req_byte[REQ_VAL_MSB:REQ_VAL_LSB];
   // Channel-aware level and offset index (2,3,5,7)
   assign chanaware_high = rval[2];
   assign chanaware_offset_idx = rval[1:0];

   // Classify by type and value code ranges
   always_comb begin
      req_class = SPHC_CL_INVALID;
      case (rtype)
         RT_NARROW: if (rval <= NB_MAX) req_class = SPHC_CL_RATE;
         RT_LEGACY: if (rval <= LEG_MAX) req_class = SPHC_CL_LEGACY;
         RT_WIDE: if (rval <= WB_MAX) req_class = SPHC_CL_RATE;
         RT_SUPERWIDE: if (rval >= SWB_MIN && rval <= WB_MAX) req_class = SPHC_CL_RATE;
         RT_FULL: if (rval >= FB_MIN && rval <= WB_MAX) req_class = SPHC_CL_RATE;
         RT_CA_WIDE, RT_CA_SUPER: if (rval <= CA_MAX) req_class = SPHC_CL_CHANAWARE;
         RT_NOREQ: if (rval == NOREQ_CODE) req_class = SPHC_CL_NONE;
         default: req_class = SPHC_CL_INVALID;
      endcase
      // Type not allowed by the session counts as non-compliant
      if (!allow_mask[rtype] && req_class != SPHC_CL_NONE) begin
         req_class = SPHC_CL_INVALID;
      end
   end
endmodule

// [hw/sphc_header_build.sv]
/*
 Builds the header byte sequence of an outgoing payload.
 Assumes the user offers frame entries one per cycle with a last mark.
*/
`timescale 1ns/1ps
module sphc_header_build
   import sphc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic start,
   input wire logic with_req,
   input wire logic [7:0] req_byte,
   input wire logic toc_valid,
   input wire logic [5:0] toc_frame_type,
   input wire logic toc_last,
   output logic toc_ready,
   output logic hdr_valid,
   output logic [7:0] hdr_byte
);
   logic req_pend_r;
   // No entry is taken while a request byte is still to go out
   assign toc_ready = ce && !req_pend_r && !(start && with_req);

   // Request byte goes out before any table-of-contents byte
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_pend_r <= 1'b0;
      end else if (ce) begin
         if (start && with_req) begin
            req_pend_r <= 1'b1;
         end else begin
            req_pend_r <= 1'b0;
         end
      end
   end

   // Output byte register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hdr_valid <= 1'b0;
         hdr_byte <= 8'h00;
      end else if (ce) begin
         hdr_valid <= 1'b0;
         if (req_pend_r) begin
            hdr_valid <= 1'b1;
            hdr_byte <= {1'b1, req_byte[6:0]};
         end else if (toc_valid && toc_ready) begin
            hdr_valid <= 1'b1;
            hdr_byte <= {1'b0, !toc_last, toc_frame_type};
         end
      end
   end
endmodule

// [hw/sphc_top.sv]
/*
 Speech payload header codec: parses received header-full payload bytes,
 latches rate requests, passes speech data, and builds outgoing headers.
 Assumes one clock, synchronous active-low reset, same-domain inputs.
*/
// Operation
// - Request byte, contents bytes, data, padding
// - Receiver discards zero padding bits
// - Top bit: 0 contents, 1 request
// - Request byte only before contents bytes
// - Requests outside session parameters are ignored
// - Accept any negotiated speech or silence frame
// - Latched request holds until newer one
// - Request byte: flag, type, value
// - Value is rate or channel-aware setting
// - Narrowband codes 0000 to 0110
// - Wideband and super-wideband rate codes
// - Fullband codes 0101 to 1011
// - Type 101 wideband channel-aware codes
// - Type 110 super-wideband channel-aware codes
// - Type 111 code 1111 means no request
// - Contents byte top bit is zero
// - Second bit flags following contents byte
`timescale 1ns/1ps
module sphc_top
   import sphc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic rx_valid,
   input wire logic rx_first,
   input wire logic rx_last,
   input wire logic [7:0] rx_byte,
   output logic rx_ready,
   output logic toc_out_valid,
   output logic [5:0] toc_out_frame_type,
   output logic data_out_valid,
   output logic [7:0] data_out_byte,
   output logic req_update,
   output logic [2:0] req_type,
   output logic [3:0] req_value,
   output logic legacy_mode,
   output logic chanaware_active,
   output logic chanaware_high,
   output logic [1:0] chanaware_offset_idx,
   input wire logic tx_start,
   input wire logic tx_toc_valid,
   input wire logic [5:0] tx_toc_frame_type,
   input wire logic tx_toc_last,
   output logic tx_toc_ready,
   output logic tx_hdr_valid,
   output logic [7:0] tx_hdr_byte
);
   sphc_pstate_type state_r;
   sphc_class_type dec_class;
   logic dec_high;
   logic [1:0] dec_ofs;
   logic [7:0] ctrl_r;
   logic [7:0] allow_r;
   logic [7:0] txreq_r;
   logic [7:0] ignored_cnt_r;
   logic [7:0] zero_run_r;
   logic flush;
   logic is_req_byte;
   logic take;

   // Stall a byte that proves held zeros to be data while they drain
   assign flush = (state_r == SPHC_P_DATA) && (zero_run_r != 8'h00) && rx_valid &&
      (rx_byte != 8'h00 || ctrl_r[1]);
   assign take = ce && rx_valid && !flush;
   assign rx_ready = ce && !flush;
   assign is_req_byte = rx_byte[TYPE_FLAG_BIT];

   // Request byte classifier
   sphc_req_decode u_dec (
      .req_byte(rx_byte),
      .allow_mask(allow_r),
      .req_class(dec_class),
      .chanaware_high(dec_high),
      .chanaware_offset_idx(dec_ofs)
   );

   // Parser state: first header byte, contents bytes, speech data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= SPHC_P_FIRST;
      end else if (take) begin
         case (state_r)
            SPHC_P_FIRST: begin
               // Request byte allowed only as first header byte
               if (!is_req_byte && !rx_byte[FOLLOW_BIT]) begin
                  state_r <= SPHC_P_DATA;
               end else begin
                  state_r <= SPHC_P_TOC;
               end
            end
            SPHC_P_TOC: begin
               // A late request byte is skipped, not read as a contents byte
               if (!is_req_byte && !rx_byte[FOLLOW_BIT]) begin
                  state_r <= SPHC_P_DATA;
               end
            end
            SPHC_P_DATA: state_r <= SPHC_P_DATA;
            default: state_r <= SPHC_P_FIRST;
         endcase
         if (rx_last) begin
            state_r <= SPHC_P_FIRST;
         end
      end
   end

   // Contents byte output; a flagged byte after the first is dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         toc_out_valid <= 1'b0;
         toc_out_frame_type <= 6'h00;
      end else if (ce) begin
         toc_out_valid <= 1'b0;
         if (take && (state_r == SPHC_P_FIRST || state_r == SPHC_P_TOC) && !is_req_byte) begin
            toc_out_valid <= 1'b1;
            toc_out_frame_type <= rx_byte[5:0];
         end
      end
   end

   // Held zero count; a run still held at the last byte is padding (runs over 255 wrap)
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         zero_run_r <= 8'h00;
      end else if (ce) begin
         if (flush) begin
            zero_run_r <= zero_run_r - 8'h01;
         end else if (take && state_r == SPHC_P_DATA && rx_byte == 8'h00 && !ctrl_r[1] && !rx_last) begin
            zero_run_r <= zero_run_r + 8'h01;
         end else if (take) begin
            zero_run_r <= 8'h00;
         end
      end
   end

   // Emit data; pending zero bytes are flushed before a nonzero byte
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_out_valid <= 1'b0;
         data_out_byte <= 8'h00;
      end else if (ce) begin
         data_out_valid <= 1'b0;
         if (flush) begin
            data_out_valid <= 1'b1; // held zero proven to be data
            data_out_byte <= 8'h00;
         end else if (take && state_r == SPHC_P_DATA && (rx_byte != 8'h00 || ctrl_r[1])) begin
            data_out_valid <= 1'b1; // every data byte passes, whatever request
            data_out_byte <= rx_byte;
         end
      end
   end

   // Latched request; replaced only by a newer compliant request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_type <= REQ_TYPE_RST;
         req_value <= REQ_VAL_RST;
         legacy_mode <= 1'b0;
         chanaware_active <= 1'b0;
         chanaware_high <= 1'b0;
         chanaware_offset_idx <= 2'h0;
         req_update <= 1'b0;
      end else if (ce) begin
         req_update <= 1'b0;
         if (take && state_r == SPHC_P_FIRST && is_req_byte && ctrl_r[0]) begin
            case (dec_class)
               SPHC_CL_RATE, SPHC_CL_LEGACY, SPHC_CL_CHANAWARE: begin
                  req_type <= rx_byte[REQ_TYPE_MSB:REQ_TYPE_LSB];
                  req_value <= rx_byte[REQ_VAL_MSB:REQ_VAL_LSB];
                  legacy_mode <= (dec_class == SPHC_CL_LEGACY);
                  chanaware_active <= (dec_class == SPHC_CL_CHANAWARE);
                  chanaware_high <= dec_high;
                  chanaware_offset_idx <= dec_ofs;
                  req_update <= 1'b1;
               end
               SPHC_CL_NONE: req_update <= 1'b0;
               default: req_update <= 1'b0;
            endcase
         end
      end
   end

   // Count ignored requests for status
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ignored_cnt_r <= 8'h00;
      end else if (take && state_r == SPHC_P_FIRST && is_req_byte && dec_class == SPHC_CL_INVALID) begin
         if (ignored_cnt_r != 8'hff) begin
            ignored_cnt_r <= ignored_cnt_r + 8'h01;
         end
      end
   end

   // Register writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         allow_r <= ALLOW_RST;
         txreq_r <= TXREQ_RST;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            OFS_CTRL: ctrl_r <= reg_wdata;
            OFS_ALLOW: allow_r <= reg_wdata;
            OFS_TXREQ: txreq_r <= reg_wdata;
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end

   // Register reads, one cycle later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (ce && reg_rd) begin
         case (reg_addr)
            OFS_CTRL: reg_rdata <= ctrl_r;
            OFS_ALLOW: reg_rdata <= allow_r;
            OFS_TXREQ: reg_rdata <= txreq_r;
            OFS_STATUS: reg_rdata <= ignored_cnt_r;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Transmit header builder; request byte inserted when enabled
   sphc_header_build u_build (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .start(tx_start),
      .with_req(ctrl_r[2]),
      .req_byte(txreq_r),
      .toc_valid(tx_toc_valid),
      .toc_frame_type(tx_toc_frame_type),
      .toc_last(tx_toc_last),
      .toc_ready(tx_toc_ready),
      .hdr_valid(tx_hdr_valid),
      .hdr_byte(tx_hdr_byte)
   );
endmodule

// [verif/sphc_assertions.sv]
/*
 Port checker for the header codec top.
 Assumes a bind to sphc_top: one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module sphc_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic rx_first,
   input wire logic [7:0] rx_byte,
   input wire logic toc_out_valid,
   input wire logic [5:0] toc_out_frame_type,
   input wire logic req_update,
   input wire logic [2:0] req_type,
   input wire logic [3:0] req_value,
   input wire logic legacy_mode,
   input wire logic chanaware_active,
   input wire logic chanaware_high,
   input wire logic [1:0] chanaware_offset_idx,
   input wire logic tx_toc_valid,
   input wire logic [5:0] tx_toc_frame_type,
   input wire logic tx_toc_last,
   input wire logic tx_toc_ready,
   input wire logic tx_hdr_valid,
   input wire logic [7:0] tx_hdr_byte
);
   logic take;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Byte accepted on this edge
   assign take = rx_valid & rx_ready;
   a_toc_frame_out: assert property (toc_out_valid |->
      $past(take && !rx_byte[7]) && toc_out_frame_type == $past(rx_byte[5:0])) else $error("contents entry wrong");
   a_req_from_first: assert property (req_update |->
      $past(take && rx_first) && {1'b1, req_type, req_value} == $past(rx_byte)) else $error("request source wrong");
   a_late_req_dropped: assert property (take && !rx_first && rx_byte[7] |=> !req_update)
      else $error("late request latched");
   a_noreq_ignored: assert property (take && rx_byte == 8'hff |=> !req_update)
      else $error("no-request code latched");
   a_nb_unused: assert property (take && rx_byte[7:4] == 4'h8 && rx_byte[3:0] > 4'h6 |=> !req_update)
      else $error("unused narrow code latched");
   a_fb_unused: assert property (take && rx_byte[7:4] == 4'hc && (rx_byte[3:0] < 4'h5 || rx_byte[3:0] > 4'hb)
      |=> !req_update) else $error("unused full code latched");
   a_ca_unused: assert property (take && rx_byte[7:4] inside {4'hd, 4'he} && rx_byte[3] |=> !req_update)
      else $error("unused chanaware code latched");
   a_req_held: assert property ($past(rst_n) && !req_update |-> $stable({req_type, req_value}))
      else $error("request changed without update");
   a_legacy_set: assert property (req_update && req_type == 3'h1 |-> ##[0:1] legacy_mode)
      else $error("legacy mode not entered");
   a_chanaware_map: assert property (req_update && req_type inside {3'h5, 3'h6} |-> ##[0:1]
      (chanaware_active && {chanaware_high, chanaware_offset_idx} == req_value[2:0])) else $error("chanaware map");
   a_tx_toc_format: assert property (tx_toc_valid && tx_toc_ready && ce |=> tx_hdr_valid &&
      tx_hdr_byte == {1'b0, !$past(tx_toc_last), $past(tx_toc_frame_type)}) else $error("tx contents byte");
endmodule

// [verif/sphc_far_end.sv]
/*
 Remote payload formatter feeding the receive port.
 Assumes the receiver may stall a byte by holding its ready low.
*/
`timescale 1ns/1ps
module sphc_far_end (
   input wire logic clk,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic rx_first,
   output logic rx_last,
   output logic [7:0] rx_byte
);
   logic [7:0] q[$];
   int worst_wait;
   // Idle line at start
   initial begin
      rx_valid = 1'b0;
      rx_first = 1'b0;
      rx_last = 1'b0;
      rx_byte = 8'h00;
   end
   // One payload; late puts the request byte after the first entry on purpose
   // nz zero bytes follow the first data byte inside the speech data
   task automatic send(input logic [7:0] req, input bit has, input bit late, input int nd, input int np, input int gap,
      input int nz);
      int k;
      q = {};
      if (has && !late) q.push_back(req);
      q.push_back(8'h4a);
      if (has && late) q.push_back(req);
      q.push_back(8'h0b);
      for (int i = 0; i < nd; i++) begin
         q.push_back(8'h31 + 8'(i));
         if (i == 0) repeat (nz) q.push_back(8'h00);
      end
      for (int i = 0; i < np; i++) q.push_back(8'h00);
      @(posedge clk);
      foreach (q[i]) begin
         rx_valid <= 1'b1;
         rx_first <= (i == 0);
         rx_last <= (i == q.size() - 1);
         rx_byte <= q[i];
         // Hold the byte until an edge samples ready high
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (rx_ready !== 1'b1 && k < 20);
         if (k > worst_wait) worst_wait = k;
         repeat (gap) begin
            rx_valid <= 1'b0;
            rx_byte <= ~rx_byte;
            @(posedge clk);
         end
      end
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      rx_last <= 1'b0;
      rx_byte <= ~rx_byte;
   endtask
endmodule

// [verif/tb_speech_payload_header_codec.sv]
/*
 Self-checking bench of the header codec top.
 Assumes the far-end model drives receive bytes; bench drives registers and tx.
*/
`timescale 1ns/1ps
module tb_speech_payload_header_codec;
   logic clk, rst_n, ce, reg_wr, reg_rd, rx_valid, rx_first, rx_last, rx_ready;
   logic [3:0] reg_addr, req_value;
   logic [7:0] reg_wdata, reg_rdata, rx_byte, data_out_byte, tx_hdr_byte;
   logic toc_out_valid, data_out_valid, req_update, legacy_mode, chanaware_active, chanaware_high;
   logic [5:0] toc_out_frame_type, tx_toc_frame_type;
   logic [2:0] req_type;
   logic [1:0] chanaware_offset_idx;
   logic tx_start, tx_toc_valid, tx_toc_last, tx_toc_ready, tx_hdr_valid;
   logic [7:0] dq[$], tq[$], txq[$];
   int upd_n, fails, check_count;
   sphc_top u_dut (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .rx_valid, .rx_first, .rx_last, .rx_byte, .rx_ready, .toc_out_valid, .toc_out_frame_type,
      .data_out_valid, .data_out_byte, .req_update, .req_type, .req_value, .legacy_mode,
      .chanaware_active, .chanaware_high, .chanaware_offset_idx, .tx_start, .tx_toc_valid,
      .tx_toc_frame_type, .tx_toc_last, .tx_toc_ready, .tx_hdr_valid, .tx_hdr_byte);
   sphc_far_end u_far (.clk, .rx_ready, .rx_valid, .rx_first, .rx_last, .rx_byte);
   always #2.5 clk = ~clk;
   // Collect one-cycle output pulses
   always @(posedge clk) begin
      if (req_update === 1'b1) upd_n++;
      if (data_out_valid === 1'b1) dq.push_back(data_out_byte);
      if (toc_out_valid === 1'b1) tq.push_back({2'b00, toc_out_frame_type});
      if (tx_hdr_valid === 1'b1) txq.push_back(tx_hdr_byte);
   end
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkq(string n, logic [7:0] q[$], logic [7:0] e[$]);
      chk(n, 8'(e.size()), 8'(q.size()));
      foreach (e[i]) chk(n, e[i], (i < q.size()) ? q[i] : 8'hxx);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e, string n);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask
   task automatic t_reset();
      chk("request", 8'h7f, {1'b0, req_type, req_value});
      chk("levels", 8'h00, {5'h00, legacy_mode, chanaware_active, chanaware_high});
      wr(4'h2, 8'h5a);
      ce <= 1'b0;
      wr(4'h4, 8'h00);
      ce <= 1'b1;
      rd(4'h0, 8'h00, "control");
      rd(4'h2, 8'h00, "unmapped");
      rd(4'h4, 8'hff, "allow mask");
      rd(4'h8, 8'hff, "tx request");
      rd(4'hc, 8'h00, "ignored count");
   endtask
   // Every request type, valid and unused codes, prompt and slow sender
   task automatic t_requests();
      logic [7:0] b[16] = '{8'h86, 8'h87, 8'h98, 8'h99, 8'hab, 8'hac, 8'hb2, 8'hb3,
         8'hc4, 8'hc5, 8'hd7, 8'hd8, 8'he0, 8'he8, 8'hf0, 8'hff};
      bit acc[16] = '{1, 0, 1, 0, 1, 0, 0, 1, 0, 1, 1, 0, 1, 0, 0, 0};
      logic [6:0] exp_req;
      int n0;
      exp_req = 7'h7f;
      wr(4'h0, 8'h01);
      foreach (b[i]) begin
         n0 = upd_n;
         u_far.send(b[i], 1'b1, 1'b0, 1, 0, (i % 2) * 2, 0);
         repeat (3) @(posedge clk);
         if (acc[i]) exp_req = b[i][6:0];
         chk("update count", 8'(acc[i]), 8'(upd_n - n0));
         chk("latched request", {1'b0, exp_req}, {1'b0, req_type, req_value});
         if (acc[i] && b[i][6:4] == 3'h1) chk("legacy", 8'h01, {7'h00, legacy_mode});
         if (acc[i] && b[i][6:4] inside {3'h5, 3'h6}) chk("chanaware", {4'h0, 1'b1, b[i][2:0]},
            {4'h0, chanaware_active, chanaware_high, chanaware_offset_idx});
      end
      wr(4'h4, 8'hfb);
      n0 = upd_n;
      u_far.send(8'ha5, 1'b1, 1'b0, 1, 0, 0, 0);
      repeat (3) @(posedge clk);
      chk("masked update", 8'h00, 8'(upd_n - n0));
      rd(4'hc, 8'h09, "ignored count");
      wr(4'h4, 8'hff);
   endtask
   // Late request byte, trailing padding, zeros inside data, zero pass mode
   task automatic t_padding();
      int n0;
      dq = {};
      tq = {};
      n0 = upd_n;
      u_far.send(8'h86, 1'b1, 1'b1, 3, 2, 0, 0);
      repeat (4) @(posedge clk);
      chk("late update", 8'h00, 8'(upd_n - n0));
      chkq("speech data", dq, {8'h31, 8'h32, 8'h33});
      chkq("contents", tq, {8'h0a, 8'h0b});
      dq = {};
      u_far.send(8'h00, 1'b0, 1'b0, 2, 1, 2, 2);
      repeat (4) @(posedge clk);
      chkq("inner zeros", dq, {8'h31, 8'h00, 8'h00, 8'h32});
      wr(4'h0, 8'h03);
      dq = {};
      u_far.send(8'h00, 1'b0, 1'b0, 1, 1, 0, 0);
      repeat (4) @(posedge clk);
      chkq("zeros passed", dq, {8'h31, 8'h00});
      stuck(u_far.worst_wait);
   endtask
   task automatic stuck(int k);
      if (k >= 20) begin
         fails++;
         $display("CHECK FAILED wait expected done seen timeout");
         wrap_up();
      end
   endtask
   // Outgoing header: request byte then two entries
   task automatic t_tx();
      int k;
      txq = {};
      wr(4'h8, 8'h25);
      wr(4'h0, 8'h05);
      @(posedge clk);
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      for (int j = 0; j < 2; j++) begin
         tx_toc_valid <= 1'b1;
         tx_toc_frame_type <= 6'h20 + 6'(j);
         tx_toc_last <= (j == 1);
         k = 0;
         #1;
         while (tx_toc_ready !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
         end
         stuck(k);
         @(posedge clk);
      end
      tx_toc_valid <= 1'b0;
      k = 0;
      while (txq.size() < 3 && k < 20) begin
         @(posedge clk);
         k++;
      end
      stuck(k);
      chkq("tx header", txq, {8'ha5, 8'h60, 8'h21});
   endtask
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_start = 1'b0;
      tx_toc_valid = 1'b0;
      tx_toc_frame_type = 6'h00;
      tx_toc_last = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_requests();
      t_padding();
      t_tx();
      wrap_up();
   end
endmodule
bind sphc_top sphc_checker u_chk (.clk, .rst_n, .ce, .rx_valid, .rx_ready, .rx_first, .rx_byte, .toc_out_valid,
   .toc_out_frame_type, .req_update, .req_type, .req_value, .legacy_mode, .chanaware_active,
   .chanaware_high, .chanaware_offset_idx, .tx_toc_valid, .tx_toc_frame_type, .tx_toc_last,
   .tx_toc_ready, .tx_hdr_valid, .tx_hdr_byte);
